/* rtl/fmvs_top.sv */
// media-valid strap block: captures two strap pins at reset and reports media-id validity
// in bit 5 of the tape drive register for the accessed drive; registers over axi4-lite
// assumes straps and track-zero are synchronous to aclk; drive select comes from software
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module fmvs_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] media_valid_strap,
   input wire logic track_zero_in,
   input wire logic [fmvs_pkg::FMVS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fmvs_pkg::FMVS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic drive_rate_select,
   output logic media_valid_n
);
   import fmvs_pkg::*;
   typedef struct packed {
      logic start_done;
      logic func_rate;
      logic drive_sel;
      logic [3:0] media_id;
      logic track_zero;
      logic rate_out;
      logic valid_n_out;
   } fmvs_top_state_t;
   fmvs_top_state_t state, next_state;
   logic [1:0] strap_q;
   logic wr_stb, wr_err, rd_err;
   logic [FMVS_ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0] wr_strb;
   logic [7:0] tdr_byte;
   logic valid_bit;

   ////////////////////////////////////////////////////////////////////////////
   // strap capture per drive
   for (genvar i = 0; i < 2; i++) begin : g_strap
      fmvs_strap_latch u_latch (
         .aclk(aclk),
         .aresetn(aresetn),
         .strap_in(media_valid_strap[i]),
         .strap_q(strap_q[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus front end
   fmvs_axil_slave #(.ADDR_W(FMVS_ADDR_W)) u_axi (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_stb(),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   ////////////////////////////////////////////////////////////////////////////
   // validity bit follows the strap of the accessed drive (low = valid)
   assign valid_bit = strap_q[state.drive_sel];
   // tape drive byte: media id of the accessed drive in 7:6, validity in 5
   always_comb begin
      tdr_byte = 8'h00;
      tdr_byte[FMVS_TDR_MEDIA_HI:FMVS_TDR_MEDIA_LO] =
         state.drive_sel ? state.media_id[3:2] : state.media_id[1:0];
      // rate mode strips meaning from the straps, report invalid
      tdr_byte[FMVS_TDR_VALID_BIT] = state.func_rate ? 1'b1 : valid_bit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read decode; unmapped addresses answer slverr with zero data
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (rd_addr == FMVS_TDR_ADDR) begin
         rd_data[7:0] = tdr_byte;
      end else if (rd_addr == FMVS_CTRL_ADDR) begin
         rd_data[FMVS_CTRL_DRV_BIT] = state.drive_sel;
         rd_data[FMVS_CTRL_MID_HI:FMVS_CTRL_MID_LO] = state.media_id;
      end else if (rd_addr == FMVS_FUNC_ADDR) begin
         rd_data[FMVS_FUNC_RATE_BIT] = state.func_rate;
      end else if (rd_addr == FMVS_STAT_ADDR) begin
         rd_data[FMVS_STAT_TRACK_BIT] = state.track_zero;
         rd_data[FMVS_STAT_STRAP_HI:FMVS_STAT_STRAP_LO] = strap_q;
      end else begin
         rd_err = 1'b1;
      end
   end

   // write decode; tape drive and status are read-only, writes there are ignored
   always_comb begin
      wr_err = 1'b0;
      if (wr_addr == FMVS_TDR_ADDR) begin
         wr_err = 1'b0;
      end else if (wr_addr == FMVS_CTRL_ADDR) begin
         wr_err = 1'b0;
      end else if (wr_addr == FMVS_FUNC_ADDR) begin
         wr_err = 1'b0;
      end else if (wr_addr == FMVS_STAT_ADDR) begin
         wr_err = 1'b0;
      end else begin
         wr_err = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register state; the function config bit loads from the frozen drive-0 strap
   // one cycle after release, because reset itself may only load constants
   always_comb begin
      next_state = state;
      // track-zero from the selected drive, kept as a status level
      next_state.track_zero = track_zero_in;
      if (!state.start_done) begin
         // drive-0 strap level loads the rate select bit
         next_state.func_rate = strap_q[0];
         next_state.start_done = 1'b1;
      end else if (wr_stb && wr_strb[0] && wr_addr == FMVS_FUNC_ADDR) begin
         next_state.func_rate = wr_data[FMVS_FUNC_RATE_BIT];
      end
      if (wr_stb && wr_addr == FMVS_CTRL_ADDR) begin
         if (wr_strb[0]) begin
            next_state.drive_sel = wr_data[FMVS_CTRL_DRV_BIT];
         end
         if (wr_strb[1]) begin
            next_state.media_id = wr_data[FMVS_CTRL_MID_HI:FMVS_CTRL_MID_LO];
         end
      end
      next_state.rate_out = next_state.func_rate;
      next_state.valid_n_out = next_state.func_rate ? 1'b1 : strap_q[next_state.drive_sel];
      if (!aresetn) begin
         next_state.start_done = 1'b0;
         next_state.func_rate = FMVS_FUNC_RST;
         next_state.drive_sel = FMVS_DRV_RST;
         next_state.media_id = FMVS_MID_RST;
         next_state.track_zero = 1'b0;
         next_state.rate_out = FMVS_FUNC_RST;
         next_state.valid_n_out = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      state <= next_state;
   end

   // outputs straight from flip-flops
   assign drive_rate_select = state.rate_out;
   assign media_valid_n = state.valid_n_out;
endmodule : fmvs_top

/* rtl/fmvs_pkg.sv */
// package for the media-valid strap block: register map, field positions, reset values
// assumes an axi4-lite register bus with 32-bit data, one register per aligned word
package fmvs_pkg;
   // tape drive register is word index 3F3h, its byte address four times that; the rest are local words
   localparam logic [11:0] FMVS_TDR_INDEX = 12'h3F3;
   localparam logic [13:0] FMVS_TDR_ADDR = {FMVS_TDR_INDEX, 2'b00};
   localparam logic [13:0] FMVS_CTRL_ADDR = 14'h0000;
   localparam logic [13:0] FMVS_FUNC_ADDR = 14'h0004;
   localparam logic [13:0] FMVS_STAT_ADDR = 14'h0008;
   localparam int FMVS_ADDR_W = 14;
   // tape drive register fields
   localparam int FMVS_TDR_VALID_BIT = 5;
   localparam int FMVS_TDR_MEDIA_LO = 6;
   localparam int FMVS_TDR_MEDIA_HI = 7;
   // function configuration register field
   localparam int FMVS_FUNC_RATE_BIT = 0;
   // control register fields: drive select and media id bits
   localparam int FMVS_CTRL_DRV_BIT = 0;
   localparam int FMVS_CTRL_MID_LO = 8;
   localparam int FMVS_CTRL_MID_HI = 11;
   // status register fields
   localparam int FMVS_STAT_TRACK_BIT = 0;
   localparam int FMVS_STAT_STRAP_LO = 1;
   localparam int FMVS_STAT_STRAP_HI = 2;
   // reset values
   localparam logic [1:0] FMVS_STRAP_RST = 2'h3;
   localparam logic FMVS_FUNC_RST = 1'b0;
   localparam logic FMVS_DRV_RST = 1'b0;
   localparam logic [3:0] FMVS_MID_RST = 4'h0;
   // axi response codes
   localparam logic [1:0] FMVS_RESP_OKAY = 2'h0;
   localparam logic [1:0] FMVS_RESP_SLVERR = 2'h2;
endpackage : fmvs_pkg

/* rtl/fmvs_strap_latch.sv */
// one strap capture cell: follows the pin while reset is held, freezes on release
// assumes the pin is synchronous to aclk and stable around the release of reset
`timescale 1ns/100ps
module fmvs_strap_latch (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic strap_in,
   output logic strap_q
);
   import fmvs_pkg::*;
   typedef struct packed {
      logic level;
   } fmvs_latch_state_t;
   fmvs_latch_state_t state, next_state;
   ////////////////////////////////////////////////////////////////////////////
   // sample during reset, hold afterwards; reset samples a pin, so it is a clocked copy not a constant
   always_comb begin
      next_state = state;
      if (!aresetn) begin
         next_state.level = strap_in;
      end
   end
   always_ff @(posedge aclk) begin
      state <= next_state;
   end
   assign strap_q = state.level;
endmodule : fmvs_strap_latch

/* rtl/fmvs_axil_slave.sv */
// axi4-lite slave front end: accepts one write and one read, hands them on as strobes
// assumes the register file answers reads combinationally from its own flip-flops
`timescale 1ns/100ps
module fmvs_axil_slave #(
   parameter int ADDR_W = fmvs_pkg::FMVS_ADDR_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_stb,
   output logic [ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic rd_stb,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   import fmvs_pkg::*;
   typedef struct packed {
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_ready;
      logic w_ready;
      logic ar_ready;
   } fmvs_axi_state_t;
   fmvs_axi_state_t state, next_state;
   logic aw_take, w_take, ar_take, do_write;

   // the decode compares whole byte addresses; a narrower bus would alias registers
   if (ADDR_W < FMVS_ADDR_W) begin : g_addr_check
      $error("address too narrow for the register map");
   end
   ////////////////////////////////////////////////////////////////////////////
   // address and data taken in either order; held until the write strobe, not taken again until the response is gone
   assign s_axi_awready = state.aw_ready;
   assign s_axi_wready = state.w_ready;
   assign s_axi_arready = state.ar_ready;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign do_write = (state.aw_held || aw_take) && (state.w_held || w_take);
   assign wr_stb = do_write;
   assign wr_addr = state.aw_held ? state.awaddr : s_axi_awaddr;
   assign wr_data = state.w_held ? state.wdata : s_axi_wdata;
   assign wr_strb = state.w_held ? state.wstrb : s_axi_wstrb;
   assign rd_stb = ar_take;
   assign rd_addr = s_axi_araddr;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_bresp = state.bresp;
   assign s_axi_rvalid = state.rvalid;
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   ////////////////////////////////////////////////////////////////////////////
   // channel bookkeeping
   always_comb begin
      next_state = state;
      if (aw_take) begin
         next_state.aw_held = 1'b1;
         next_state.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         next_state.w_held = 1'b1;
         next_state.wdata = s_axi_wdata;
         next_state.wstrb = s_axi_wstrb;
      end
      if (do_write) begin
         next_state.aw_held = 1'b0;
         next_state.w_held = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = wr_err ? FMVS_RESP_SLVERR : FMVS_RESP_OKAY;
      end else if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      if (ar_take) begin
         next_state.rvalid = 1'b1;
         next_state.rdata = rd_data;
         next_state.rresp = rd_err ? FMVS_RESP_SLVERR : FMVS_RESP_OKAY;
      end else if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      if (!aresetn) begin
         next_state = '0;
      end
      // readies are flops so the bus sees no gate path; they follow the next held and bvalid/rvalid flags
      next_state.aw_ready = !next_state.aw_held && !next_state.bvalid;
      next_state.w_ready = !next_state.w_held && !next_state.bvalid;
      next_state.ar_ready = !next_state.rvalid;
   end
   always_ff @(posedge aclk) begin
      state <= next_state;
   end
endmodule : fmvs_axil_slave

/* verif/fmvs_chk.sv */
// checker for the strap block: strap capture, validity pin and bus handshakes
// assumes it is bound to fmvs_top and sees only its ports
`timescale 1ns/100ps
module fmvs_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] media_valid_strap,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic drive_rate_select,
   input wire logic media_valid_n
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // strap capture: last low edge of reset is three edges back once outputs settle
   rate_from_strap_a: assert property ($rose(aresetn) |->
      ##2 drive_rate_select == $past(media_valid_strap[0], 3))
      else $error("rate select not loaded from drive 0 strap");
   valid_from_strap_a: assert property ($rose(aresetn) |->
      ##2 media_valid_n == $past(media_valid_strap[0], 3))
      else $error("validity pin does not follow drive 0 strap");
   // rate mode forces invalid; both pins load from the same next value, so no grace cycle
   rate_forces_invalid_a: assert property (drive_rate_select |-> media_valid_n)
      else $error("validity reported while in rate mode");
   // pins may wander after reset; only a register write may move the flag
   valid_frozen_a: assert property ($changed(media_valid_n) && $past(aresetn, 3) |->
      s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("validity flag moved without a write");
   ////////////////////////////////////////////////////////////////////////////////
   // bus handshakes
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while response pending");
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (drive_rate_select && media_valid_n);
endmodule : fmvs_chk

/* verif/fmvs_drive_model.sv */
// board-side model: pull-ups on the two strap pins and the selected drive's track sensor
// assumes the bench says which pull-ups are fitted and where the head sits
`timescale 1ns/100ps
module fmvs_drive_model (
   input wire logic aclk,
   input wire logic [1:0] pullup_fit,
   input wire logic head_outer,
   output logic [1:0] media_valid_strap,
   output logic track_zero_in
);
   // pins move just after an edge; no pull-up leaves the internal pull-down low
   always_ff @(posedge aclk) begin
      media_valid_strap <= pullup_fit;
      track_zero_in <= head_outer;
   end
endmodule : fmvs_drive_model

/* verif/floppy_media_valid_strap_tb.sv */
// bench for the strap block: axi4-lite register tasks and strap scenarios
// assumes the drive model supplies the pins; checker bound at the foot
`timescale 1ns/100ps
module floppy_media_valid_strap_tb;
   import fmvs_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [1:0] pullup_fit = 2'h0;
   logic head_outer = 1'b0;
   logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, media_valid_strap, s;
   logic [31:0] s_axi_rdata, rd_d;
   logic drive_rate_select, media_valid_n, track_zero_in;
   int err_total = 0;
   int samples_checked = 0;
   always #5 aclk = ~aclk;
   fmvs_top dut_u (.aclk, .aresetn, .media_valid_strap, .track_zero_in, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .drive_rate_select, .media_valid_n);
   fmvs_drive_model board_u (.aclk, .pullup_fit, .head_outer, .media_valid_strap, .track_zero_in);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   // write: both channels offered together, each dropped at the edge that takes it
   task automatic axi_wr(input logic [13:0] a, input logic [31:0] d);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && !b_t; n++) begin
         @(negedge aclk);
         aw_t = (s_axi_awvalid & s_axi_awready) === 1'b1;
         w_t = (s_axi_wvalid & s_axi_wready) === 1'b1;
         b_t = s_axi_bvalid === 1'b1;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (!b_t) begin
         err_total++;
         conclude();
      end
   endtask : axi_wr
   // read: ready levels seen mid-cycle are those the next edge samples
   task automatic axi_rd(input logic [13:0] a);
      logic ar_t, r_t;
      r_t = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && !r_t; n++) begin
         @(negedge aclk);
         ar_t = (s_axi_arvalid & s_axi_arready) === 1'b1;
         r_t = s_axi_rvalid === 1'b1;
         rd_d = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (!r_t) begin
         err_total++;
         conclude();
      end
   endtask : axi_rd
   ////////////////////////////////////////////////////////////////////////////////
   // every strap pattern: capture, freeze, per-drive flag, rate mode override
   initial begin
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         @(posedge aclk);
         aresetn <= 1'b0;
         pullup_fit <= s;
         repeat (5) @(posedge aclk);
         aresetn <= 1'b1;
         axi_rd(FMVS_FUNC_ADDR);
         check("config bit", {31'h0, s[0]}, rd_d);
         @(negedge aclk);
         check("rate pin", {31'h0, s[0]}, {31'h0, drive_rate_select});
         check("valid pin d0", {31'h0, s[0]}, {31'h0, media_valid_n});
         @(posedge aclk);
         pullup_fit <= ~s;
         repeat (3) @(posedge aclk);
         axi_rd(FMVS_CTRL_ADDR);
         check("ctrl reset", 32'h0, rd_d);
         axi_rd(FMVS_STAT_ADDR);
         check("frozen straps", {29'h0, s, 1'b0}, rd_d & 32'h6);
         axi_wr(FMVS_FUNC_ADDR, 32'h0);
         for (int d = 0; d < 2; d++) begin
            axi_wr(FMVS_CTRL_ADDR, {20'h0, 4'h9, 7'h0, d[0]});
            axi_rd(FMVS_TDR_ADDR);
            check("tdr valid", {31'h0, s[d]}, {31'h0, rd_d[5]});
            check("tdr media id", (d == 1) ? 32'h2 : 32'h1, {30'h0, rd_d[7:6]});
            @(negedge aclk);
            check("valid pin", {31'h0, s[d]}, {31'h0, media_valid_n});
         end
         axi_wr(FMVS_FUNC_ADDR, 32'h1);
         axi_rd(FMVS_TDR_ADDR);
         check("tdr forced", 32'h1, {31'h0, rd_d[5]});
         @(negedge aclk);
         check("valid pin forced", 32'h1, {31'h0, media_valid_n});
         check("rate pin written", 32'h1, {31'h0, drive_rate_select});
      end
      // head at the outer track and back
      for (int t = 1; t >= 0; t--) begin
         @(posedge aclk);
         head_outer <= t[0];
         repeat (3) @(posedge aclk);
         axi_rd(FMVS_STAT_ADDR);
         check("track zero", {31'h0, t[0]}, rd_d & 32'h1);
      end
      // read-only write ignored, unmapped read refused
      axi_wr(FMVS_TDR_ADDR, 32'h0);
      check("tdr write resp", {30'h0, FMVS_RESP_OKAY}, {30'h0, resp});
      axi_rd(14'h0100);
      check("unmapped resp", {30'h0, FMVS_RESP_SLVERR}, {30'h0, resp});
      check("unmapped data", 32'h0, rd_d);
      axi_wr(14'h0100, 32'h0);
      check("unmapped write resp", {30'h0, FMVS_RESP_SLVERR}, {30'h0, resp});
      conclude();
   end
endmodule : floppy_media_valid_strap_tb
bind fmvs_top fmvs_chk chk_u (.aclk, .aresetn, .media_valid_strap, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .drive_rate_select, .media_valid_n);
